// [hw/exec_pkg.sv]
// Shared constants and types of the extended instruction executor.
package exec_pkg;

  // ****************************************************************
  // Widths and memory sizes
  // ****************************************************************
  localparam int unsigned DM_AW = 11;
  localparam int unsigned PM_AW = 14;
  localparam int unsigned PAGE_W = 6;
  localparam int unsigned STACK_DEPTH = 12;
  localparam logic [3:0] SP_LAST = 4'hB;
  localparam logic [3:0] SP_STEP = 4'h1;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 6'h3F;
  localparam logic [DM_AW-1:0] PCL_DM_ADDR = 11'h006;
  localparam logic [PM_AW-1:0] PC_STEP = 14'h0001;
  localparam logic [PM_AW-1:0] PC_SKIP = 14'h0002;

  // ****************************************************************
  // Reset values and watchdog
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PM_AW-1:0] RST_PC = 14'h0000;
  localparam logic [15:0] RST_WDT = 16'h0000;
  localparam logic [15:0] WDT_STEP = 16'h0001;
  localparam logic [15:0] WDT_LIMIT = 16'hFFFF;

  // ****************************************************************
  // Status bits and update masks
  // ****************************************************************
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_AC = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_PDF = 4;
  localparam int unsigned FLAG_TO = 5;
  localparam int unsigned FLAG_SC = 6;
  localparam int unsigned FLAG_CZ = 7;
  localparam logic [7:0] UPD_ARITH = 8'h4F;
  localparam logic [7:0] UPD_CZ = 8'h80;
  localparam logic [7:0] UPD_Z = 8'h04;
  localparam logic [7:0] UPD_C = 8'h01;
  localparam logic [7:0] UPD_KEEP_C = 8'hFE;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  // ****************************************************************
  // Register port map
  // ****************************************************************
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_TABLE_POINTER = 3'h2;
  localparam logic [2:0] REG_TABLE_HIGH_BYTE_REG = 3'h3;
  localparam logic [2:0] REG_TBHP = 3'h4;
  localparam logic [2:0] REG_PCL = 3'h5;
  localparam logic [2:0] REG_PCH = 3'h6;
  localparam logic [2:0] REG_SP = 3'h7;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_ADC = 5'h01, OP_SUB = 5'h02, OP_SBC = 5'h03,
    OP_AND = 5'h04, OP_OR = 5'h05, OP_XOR = 5'h06, OP_CPL = 5'h07,
    OP_INC = 5'h08, OP_DEC = 5'h09, OP_RR = 5'h0A, OP_RRC = 5'h0B,
    OP_RL = 5'h0C, OP_RLC = 5'h0D, OP_MOV = 5'h0E, OP_CLRB = 5'h0F,
    OP_SETB = 5'h10, OP_SZ = 5'h11, OP_SNZ = 5'h12, OP_SZB = 5'h13,
    OP_SNZB = 5'h14, OP_SIZ = 5'h15, OP_SDZ = 5'h16, OP_TABRD = 5'h17,
    OP_CLR = 5'h18, OP_SET = 5'h19, OP_SWAP = 5'h1A, OP_DAA = 5'h1B,
    OP_CALL = 5'h1C, OP_CLRWDT = 5'h1D, OP_NOP = 5'h1E
  } op_e;

endpackage : exec_pkg

// [hw/exec_alu_if.sv]
// Operand and result bundle between the executor and its ALU.
`timescale 1ns/10ps
interface exec_alu_if;
  import exec_pkg::*;
  op_e op;
  logic to_mem;
  logic [7:0] a;
  logic [7:0] m;
  logic [2:0] bit_idx;
  logic [7:0] flags_in;
  logic [7:0] res;
  logic [7:0] flags_out;
  logic [7:0] upd;
  logic wr;
  logic mem_dst;
  logic skip;
  modport core (output op, to_mem, a, m, bit_idx, flags_in,
                input res, flags_out, upd, wr, mem_dst, skip);
  modport alu (input op, to_mem, a, m, bit_idx, flags_in,
               output res, flags_out, upd, wr, mem_dst, skip);
endinterface : exec_alu_if

// [hw/exec_alu.sv]
// Combinational result, flag and skip logic of the executor.
`timescale 1ns/10ps
module exec_alu (
  exec_alu_if.alu bus
);
  import exec_pkg::*;

  logic [7:0] b;
  logic [7:0] msk;
  logic [7:0] adj;
  logic cin;
  logic lo_adj;
  logic hi_adj;
  logic [8:0] sum;
  logic [4:0] nib;

  // ****************************************************************
  // Adder, shared by add, subtract and decimal adjust
  // ****************************************************************
  always_comb
  begin
    msk = 8'h01 << bus.bit_idx;
    lo_adj = (bus.a[3:0] > BCD_MAX) || bus.flags_in[FLAG_AC]; // [RULE_14]
    hi_adj = (bus.a[7:4] > BCD_MAX) || bus.flags_in[FLAG_C]; // [RULE_14]
    adj = {hi_adj ? BCD_FIX : 4'h0, lo_adj ? BCD_FIX : 4'h0}; // [RULE_15]
    b = bus.m;
    cin = 1'b0;
    if (bus.op == OP_SUB || bus.op == OP_SBC)
    begin
      b = ~bus.m;
    end
    if (bus.op == OP_DAA)
    begin
      b = adj;
    end
    if (bus.op == OP_SUB)
    begin
      cin = 1'b1;
    end
    if (bus.op == OP_ADC || bus.op == OP_SBC)
    begin
      cin = bus.flags_in[FLAG_C]; // [RULE_07]
    end
    sum = {1'b0, bus.a} + {1'b0, b} + {8'h00, cin};
    nib = {1'b0, bus.a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  end

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  always_comb
  begin
    bus.res = bus.m;
    bus.flags_out = bus.flags_in;
    bus.upd = 8'h00;
    bus.wr = 1'b0;
    bus.mem_dst = bus.to_mem;
    bus.skip = 1'b0;
    unique case (bus.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC:
      begin
        bus.res = sum[7:0]; // [RULE_07] [RULE_08] [RULE_19]
        bus.wr = 1'b1;
        bus.upd = UPD_ARITH; // [RULE_06]
        bus.flags_out[FLAG_C] = sum[8];
        bus.flags_out[FLAG_AC] = nib[4];
        bus.flags_out[FLAG_OV] = (bus.a[7] == b[7]) && (sum[7] != bus.a[7]);
        bus.flags_out[FLAG_SC] = bus.flags_out[FLAG_OV] ^ sum[7];
        if (bus.op == OP_SUB || bus.op == OP_SBC)
        begin
          bus.upd = UPD_ARITH | UPD_CZ; // [RULE_06]
          bus.flags_out[FLAG_CZ] = (sum[7:0] == 8'h00) &&
            (bus.op == OP_SUB || bus.flags_in[FLAG_CZ]);
        end
      end
      OP_AND, OP_OR, OP_XOR:
      begin
        bus.wr = 1'b1;
        bus.upd = UPD_Z; // [RULE_09]
        bus.res = (bus.op == OP_AND) ? (bus.a & bus.m) :
          (bus.op == OP_OR) ? (bus.a | bus.m) : (bus.a ^ bus.m);
      end
      OP_CPL:
      begin
        bus.res = ~bus.m; // [RULE_13]
        bus.wr = 1'b1;
        bus.upd = UPD_Z;
      end
      OP_INC, OP_DEC:
      begin
        bus.res = (bus.op == OP_INC) ? bus.m + 8'h01 : bus.m - 8'h01;
        bus.wr = 1'b1;
        bus.upd = UPD_Z;
      end
      OP_RR, OP_RL:
      begin
        bus.wr = 1'b1; // [RULE_16]
        bus.res = (bus.op == OP_RR) ? {bus.m[0], bus.m[7:1]} :
          {bus.m[6:0], bus.m[7]};
      end
      OP_RRC, OP_RLC:
      begin
        bus.wr = 1'b1;
        bus.upd = UPD_C; // [RULE_16]
        bus.res = (bus.op == OP_RRC) ?
          {bus.flags_in[FLAG_C], bus.m[7:1]} :
          {bus.m[6:0], bus.flags_in[FLAG_C]};
        bus.flags_out[FLAG_C] = (bus.op == OP_RRC) ? bus.m[0] : bus.m[7];
      end
      OP_MOV:
      begin
        bus.wr = 1'b1;
        bus.res = bus.to_mem ? bus.a : bus.m;
      end
      OP_CLRB, OP_SETB:
      begin
        bus.wr = 1'b1; // [RULE_17]
        bus.mem_dst = 1'b1;
        bus.res = (bus.op == OP_SETB) ? (bus.m | msk) : (bus.m & ~msk);
      end
      OP_SZ, OP_SNZ:
      begin
        bus.wr = !bus.to_mem;
        bus.skip = (bus.m == 8'h00) ^ (bus.op == OP_SNZ); // [RULE_03]
      end
      OP_SZB, OP_SNZB:
      begin
        bus.skip = ((bus.m & msk) == 8'h00) ^ (bus.op == OP_SNZB);
      end
      OP_SIZ, OP_SDZ:
      begin
        bus.wr = 1'b1;
        bus.res = (bus.op == OP_SIZ) ? bus.m + 8'h01 : bus.m - 8'h01;
        bus.skip = (bus.res == 8'h00);
      end
      OP_CLR, OP_SET:
      begin
        bus.wr = 1'b1; // [RULE_11]
        bus.mem_dst = 1'b1;
        bus.res = (bus.op == OP_SET) ? 8'hFF : 8'h00;
      end
      OP_SWAP:
      begin
        bus.wr = 1'b1;
        bus.res = {bus.m[3:0], bus.m[7:4]};
      end
      OP_DAA:
      begin
        bus.wr = 1'b1; // [RULE_15]
        bus.mem_dst = 1'b1;
        bus.res = sum[7:0];
        bus.upd = UPD_C;
        bus.flags_out[FLAG_C] = bus.flags_in[FLAG_C] | hi_adj | sum[8]; // [RULE_18]
      end
      default:
      begin
        bus.wr = 1'b0;
      end
    endcase
    if (bus.upd[FLAG_Z])
    begin
      bus.flags_out[FLAG_Z] = (bus.res == 8'h00);
    end
  end

endmodule : exec_alu

// [hw/ext_exec_core.sv]
// Executor for the long-address instruction group of an 8-bit core.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
// What this block does
// [RULE_01] Long instructions address any data sector directly.
// [RULE_02] Plain long instructions take two cycles.
// [RULE_03] Long skip: three cycles if skipped, else two.
// [RULE_04] Writing program counter low byte takes three.
// [RULE_05] Table read: three cycles, high byte register.
// [RULE_06] Add and subtract update their listed flags.
// [RULE_07] Add with carry sums accumulator, operand, carry.
// [RULE_08] Plain add sums accumulator with operand.
// [RULE_09] Bitwise and touches only the zero flag.
// [RULE_10] Call pushes next address, loads target, two cycles.
// [RULE_11] Clear writes zero; bit form one bit.
// [RULE_12] Watchdog clear zeroes counter and power-down; timeout too, unless wdt_q equals WDT_LIMIT in that cycle.
// [RULE_13] Complement inverts operand and updates zero flag.
// [RULE_14] Decimal adjust adds six per nibble condition.
// [RULE_15] Decimal adjust result to memory, only carry.
// [RULE_16] Rotates through carry update carry; others none.
// [RULE_17] Long bit set and clear: one bit.
// [RULE_18] Decimal adjust sets carry past one hundred.
// [RULE_19] Long forms compute like their short forms.
module ext_exec_core (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire exec_pkg::op_e instr_op_i,
  input wire logic instr_to_mem_i,
  input wire logic [exec_pkg::DM_AW-1:0] instr_addr_i,
  input wire logic [2:0] instr_bit_i,
  input wire logic instr_use_imm_i,
  input wire logic [7:0] instr_imm_i,
  input wire logic instr_incr_i,
  input wire logic instr_last_i,
  input wire logic [exec_pkg::PM_AW-1:0] instr_target_i,
  output logic busy_o,
  output logic skip_o,
  output logic [exec_pkg::PM_AW-1:0] pc_o,
  output logic [exec_pkg::DM_AW-1:0] dm_addr_o,
  output logic dm_re_o,
  output logic dm_we_o,
  output logic [7:0] dm_wdata_o,
  input wire logic [7:0] dm_rdata_i,
  output logic [exec_pkg::PM_AW-1:0] pm_addr_o,
  output logic pm_re_o,
  input wire logic [15:0] pm_rdata_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);
  import exec_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10,
    ST_EXTRA = 2'b11
  } state_e;

  state_e state_q, state_d;
  op_e op_q;
  logic to_mem_q, use_imm_q, busy_q, skip_q, dm_re_q, dm_we_q, pm_re_q;
  logic [DM_AW-1:0] addr_q, dm_addr_q;
  logic [2:0] bit_q;
  logic [7:0] imm_q, acc_q, status_q, table_pointer_q, table_high_byte_reg_q, dm_wdata_q;
  logic [7:0] reg_rdata_q, m_val, table_pointer_next;
  logic [PAGE_W-1:0] tbhp_q;
  logic [PM_AW-1:0] target_q, pc_q, pm_addr_q;
  logic [PM_AW-1:0] stack_q [STACK_DEPTH];
  logic [3:0] sp_q;
  logic [15:0] wdt_q;
  logic [1:0] cnt_q;
  logic accept, in_exec, pcl_hit, need_extra;

  exec_alu_if alu_bus ();

  exec_alu u_alu (
    .bus(alu_bus.alu)
  );

  // ****************************************************************
  // Operand routing
  // ****************************************************************
  assign accept = instr_valid_i && (state_q == ST_IDLE);
  assign in_exec = (state_q == ST_EXEC);
  assign table_pointer_next = instr_incr_i ? table_pointer_q + 8'h01 : table_pointer_q;
  assign m_val = use_imm_q ? imm_q :
    ((addr_q == PCL_DM_ADDR) ? pc_q[7:0] : dm_rdata_i); // [RULE_08]
  assign pcl_hit = alu_bus.wr && alu_bus.mem_dst &&
    (addr_q == PCL_DM_ADDR);
  assign need_extra = alu_bus.skip || pcl_hit || (op_q == OP_TABRD);
  assign alu_bus.op = op_q;
  assign alu_bus.to_mem = to_mem_q;
  assign alu_bus.a = acc_q;
  assign alu_bus.m = m_val;
  assign alu_bus.bit_idx = bit_q;
  assign alu_bus.flags_in = status_q;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        state_d = ST_EXEC; // [RULE_02]
      end
      ST_EXEC:
      begin
        state_d = need_extra ? ST_EXTRA : ST_IDLE; // [RULE_03] [RULE_04]
      end
      ST_EXTRA:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      cnt_q <= 2'b00;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= (state_d != ST_IDLE);
      cnt_q <= accept ? 2'b00 : (busy_q ? cnt_q + 2'b01 : cnt_q);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_q <= OP_NOP;
      to_mem_q <= 1'b0;
      addr_q <= '0;
      bit_q <= 3'h0;
      use_imm_q <= 1'b0;
      imm_q <= RST_BYTE;
      target_q <= RST_PC;
    end
    else if (accept)
    begin
      op_q <= instr_op_i;
      to_mem_q <= instr_to_mem_i;
      addr_q <= instr_addr_i;
      bit_q <= instr_bit_i;
      use_imm_q <= instr_use_imm_i;
      imm_q <= instr_imm_i;
      target_q <= instr_target_i;
    end
  end

  // ****************************************************************
  // Data and program memory ports
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dm_addr_q <= '0;
      dm_re_q <= 1'b0;
      dm_we_q <= 1'b0;
      dm_wdata_q <= RST_BYTE;
    end
    else
    begin
      dm_re_q <= accept && !instr_use_imm_i;
      if (accept)
      begin
        dm_addr_q <= instr_addr_i; // [RULE_01]
      end
      dm_we_q <= 1'b0;
      if (in_exec && op_q == OP_TABRD)
      begin
        dm_we_q <= 1'b1; // [RULE_05]
        dm_wdata_q <= pm_rdata_i[7:0];
      end
      else if (in_exec && alu_bus.wr && alu_bus.mem_dst && !pcl_hit)
      begin
        dm_we_q <= 1'b1; // [RULE_13] [RULE_16]
        dm_wdata_q <= alu_bus.res;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pm_re_q <= 1'b0;
      pm_addr_q <= RST_PC;
      table_pointer_q <= RST_BYTE;
      table_high_byte_reg_q <= RST_BYTE;
      tbhp_q <= '0;
    end
    else
    begin
      pm_re_q <= accept && (instr_op_i == OP_TABRD);
      if (reg_wr_i && reg_addr_i == REG_TABLE_POINTER)
      begin
        table_pointer_q <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == REG_TBHP)
      begin
        tbhp_q <= reg_wdata_i[PAGE_W-1:0];
      end
      if (accept && instr_op_i == OP_TABRD)
      begin
        table_pointer_q <= table_pointer_next; // [RULE_05]
        pm_addr_q <= {instr_last_i ? LAST_PAGE : tbhp_q, table_pointer_next};
      end
      if (in_exec && op_q == OP_TABRD)
      begin
        table_high_byte_reg_q <= pm_rdata_i[15:8]; // [RULE_05]
      end
    end
  end

  // ****************************************************************
  // Accumulator, status and watchdog
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_q <= RST_BYTE;
    end
    else if (in_exec && alu_bus.wr && !alu_bus.mem_dst)
    begin
      acc_q <= alu_bus.res; // [RULE_07] [RULE_13] [RULE_19]
    end
    else if (reg_wr_i && reg_addr_i == REG_ACC)
    begin
      acc_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status_q <= RST_BYTE;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == REG_STATUS)
      begin
        status_q <= reg_wdata_i;
      end
      if (in_exec)
      begin
        status_q <= (status_q & ~alu_bus.upd) |
          (alu_bus.flags_out & alu_bus.upd); // [RULE_06] [RULE_09]
      end
      if (in_exec && op_q == OP_CLRWDT)
      begin
        status_q[FLAG_TO] <= 1'b0; // [RULE_12]
        status_q[FLAG_PDF] <= 1'b0;
      end
      if (wdt_q == WDT_LIMIT)
      begin
        status_q[FLAG_TO] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wdt_q <= RST_WDT;
    end
    else
    begin
      wdt_q <= (in_exec && op_q == OP_CLRWDT) ? RST_WDT : wdt_q + WDT_STEP; // [RULE_12]
    end
  end

  // ****************************************************************
  // Program counter and return stack
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pc_q <= RST_PC;
      sp_q <= 4'h0;
      skip_q <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stack_q[i] <= RST_PC;
      end
    end
    else if (accept)
    begin
      skip_q <= 1'b0;
    end
    else if (in_exec)
    begin
      skip_q <= alu_bus.skip && !pcl_hit;
      if (op_q == OP_CALL)
      begin
        stack_q[sp_q] <= pc_q + PC_STEP; // [RULE_10]
        sp_q <= (sp_q == SP_LAST) ? 4'h0 : sp_q + SP_STEP;
        pc_q <= target_q;
      end
      else if (pcl_hit)
      begin
        pc_q[7:0] <= alu_bus.res; // [RULE_04]
      end
      else
      begin
        pc_q <= pc_q + (alu_bus.skip ? PC_SKIP : PC_STEP); // [RULE_03]
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_rdata_q <= RST_BYTE;
    end
    else if (!reg_rd_i)
    begin
      reg_rdata_q <= RST_BYTE;
    end
    else
    begin
      unique case (reg_addr_i)
        REG_ACC: reg_rdata_q <= acc_q;
        REG_STATUS: reg_rdata_q <= status_q;
        REG_TABLE_POINTER: reg_rdata_q <= table_pointer_q;
        REG_TABLE_HIGH_BYTE_REG: reg_rdata_q <= table_high_byte_reg_q;
        REG_TBHP: reg_rdata_q <= {2'b00, tbhp_q};
        REG_PCL: reg_rdata_q <= pc_q[7:0];
        REG_PCH: reg_rdata_q <= {2'b00, pc_q[PM_AW-1:8]};
        REG_SP: reg_rdata_q <= {4'h0, sp_q};
      endcase
    end
  end

  assign busy_o = busy_q;
  assign skip_o = skip_q;
  assign pc_o = pc_q;
  assign dm_addr_o = dm_addr_q;
  assign dm_re_o = dm_re_q;
  assign dm_we_o = dm_we_q;
  assign dm_wdata_o = dm_wdata_q;
  assign pm_addr_o = pm_addr_q;
  assign pm_re_o = pm_re_q;
  assign reg_rdata_o = reg_rdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_plain_two_cyc: assert property (@(posedge ref_clk_i) // [RULE_02]
    disable iff (!arst_n_i) (in_exec && !need_extra) |=> (!busy_q && cnt_q == 2'd2))
    else $error("plain instruction not two cycles");
  a_skip_three: assert property (@(posedge ref_clk_i) // [RULE_03]
    disable iff (!arst_n_i) (in_exec && alu_bus.skip && !pcl_hit)
    |=> busy_q ##1 (!busy_q && cnt_q == 2'd3 && pc_q == $past(pc_q, 2) + 14'd2))
    else $error("skip timing or target wrong");
  a_pcl_three: assert property (@(posedge ref_clk_i) // [RULE_04]
    disable iff (!arst_n_i) (in_exec && pcl_hit)
    |=> (pc_q[7:0] == $past(alu_bus.res)) ##1 (!busy_q && cnt_q == 2'd3))
    else $error("low byte write not three cycles");
  a_table_time: assert property (@(posedge ref_clk_i) // [RULE_05]
    disable iff (!arst_n_i) (accept && instr_op_i == OP_TABRD)
    |=> busy_q [*3] ##1 !busy_q)
    else $error("table read not three cycles");
  a_table_load: assert property (@(posedge ref_clk_i) // [RULE_05]
    disable iff (!arst_n_i) (in_exec && op_q == OP_TABRD)
    |=> (table_high_byte_reg_q == $past(pm_rdata_i[15:8]) && dm_we_o &&
    dm_wdata_o == $past(pm_rdata_i[7:0])))
    else $error("table bytes misplaced");
  a_call_push: assert property (@(posedge ref_clk_i) // [RULE_10]
    disable iff (!arst_n_i) (in_exec && op_q == OP_CALL)
    |=> (pc_q == $past(target_q) && status_q == $past(status_q) &&
    stack_q[$past(sp_q)] == $past(pc_q) + 14'd1 && cnt_q == 2'd2))
    else $error("call push or target wrong");
  a_wdt_clear: assert property (@(posedge ref_clk_i) // [RULE_12]
    disable iff (!arst_n_i) (in_exec && op_q == OP_CLRWDT && wdt_q != WDT_LIMIT)
    |=> (wdt_q == 16'd0 && !status_q[FLAG_TO] && !status_q[FLAG_PDF]))
    else $error("watchdog clear incomplete");
  a_bit_only: assert property (@(posedge ref_clk_i) // [RULE_17]
    disable iff (!arst_n_i) (in_exec && (op_q == OP_CLRB || op_q == OP_SETB))
    |=> (dm_we_o && status_q == $past(status_q) &&
    dm_wdata_o[$past(bit_q)] == ($past(op_q) == OP_SETB) &&
    ((dm_wdata_o ^ $past(m_val)) & ~(8'h01 << $past(bit_q))) == 8'h00))
    else $error("bit operation touched other bits");
  a_daa_carry: assert property (@(posedge ref_clk_i) // [RULE_15]
    disable iff (!arst_n_i) (in_exec && op_q == OP_DAA && wdt_q != WDT_LIMIT)
    |=> ((status_q & UPD_KEEP_C) == ($past(status_q) & UPD_KEEP_C) && dm_we_o))
    else $error("decimal adjust altered other flags");

endmodule : ext_exec_core

// [bench/mem_model.sv]
// Data and program memory model beside the executor.
`timescale 1ns/10ps
module mem_model (
  input wire logic ref_clk_i,
  input wire logic [10:0] dm_addr_i,
  input wire logic dm_re_i,
  input wire logic dm_we_i,
  input wire logic [7:0] dm_wdata_i,
  output logic [7:0] dm_rdata_o,
  input wire logic [13:0] pm_addr_i,
  input wire logic pm_re_i,
  output logic [15:0] pm_rdata_o
);
  logic [7:0] dm [2048];
  initial {dm_rdata_o, pm_rdata_o} = 24'h00_0000;
  // Answers the cycle after a strobe; otherwise the lines toggle.
  always @(posedge ref_clk_i)
  begin
    if (dm_we_i)
      dm[dm_addr_i] <= dm_wdata_i;
    dm_rdata_o <= dm_re_i ? dm[dm_addr_i] : ~dm_rdata_o;
    pm_rdata_o <= pm_re_i ? {2'b10, pm_addr_i} : ~pm_rdata_o;
  end
endmodule : mem_model

// [bench/ext_exec_core_tb.sv]
// Self-checking bench of the long-address executor.
`timescale 1ns/10ps
module ext_exec_core_tb;
  import exec_pkg::*;
  logic ref_clk_i = 1'b0, arst_n_i = 1'b0, instr_valid_i = 1'b0;
  logic instr_to_mem_i = 1'b0, instr_use_imm_i = 1'b0, instr_incr_i = 1'b0;
  logic instr_last_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic busy_o, skip_o, dm_re_o, dm_we_o, pm_re_o;
  op_e instr_op_i = OP_NOP;
  op_e op;
  logic [10:0] instr_addr_i = 11'h000, dm_addr_o, ad;
  logic [2:0] instr_bit_i = 3'h0, reg_addr_i = 3'h0;
  logic [7:0] instr_imm_i = 8'h00, reg_wdata_i = 8'h00;
  logic [7:0] dm_wdata_o, dm_rdata_i, reg_rdata_o, v, a, m;
  logic [13:0] instr_target_i = 14'h0000, pc_o, pm_addr_o, p;
  logic [15:0] pm_rdata_i, n, e;
  logic [31:0] k;
  logic [31:0] dt [4] = '{32'hA502_0B03, 32'h3400_3400, 32'h3C00_4200,
    32'h9101_F101};
  integer seed = 62808, error_cnt = 0, n_checks = 0;
  ext_exec_core dut_u (.ref_clk_i, .arst_n_i, .instr_valid_i, .instr_op_i,
    .instr_to_mem_i, .instr_addr_i, .instr_bit_i, .instr_use_imm_i,
    .instr_imm_i, .instr_incr_i, .instr_last_i, .instr_target_i, .busy_o,
    .skip_o, .pc_o, .dm_addr_o, .dm_re_o, .dm_we_o, .dm_wdata_o, .dm_rdata_i,
    .pm_addr_o, .pm_re_o, .pm_rdata_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o);
  mem_model mem_u (.ref_clk_i, .dm_addr_i(dm_addr_o), .dm_re_i(dm_re_o),
    .dm_we_i(dm_we_o), .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i),
    .pm_addr_i(pm_addr_o), .pm_re_i(pm_re_o), .pm_rdata_o(pm_rdata_i));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  task chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, s);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // One register write or read; read data land in v.
  task bus(input logic w, input logic [2:0] ra, input logic [7:0] d);
    @(posedge ref_clk_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, ra, d};
    @(posedge ref_clk_i);
    {reg_wr_i, reg_rd_i} <= 2'b00;
    #1 v = reg_rdata_o;
  endtask : bus
  // Issues one instruction and counts its busy cycles into n.
  task run(input op_e o, input logic tm, input logic [10:0] ma);
    @(posedge ref_clk_i);
    {instr_valid_i, instr_to_mem_i, instr_addr_i} <= {1'b1, tm, ma};
    instr_op_i <= o;
    p = pc_o;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    #1 n = 16'h0000;
    while (busy_o === 1'b1 && n < 9)
    begin
      n++;
      @(posedge ref_clk_i);
      #1;
    end
    chk(n < 9, 1'b1, "busy hang");
    if (n == 9)
      give_verdict;
    repeat (2) @(posedge ref_clk_i);
  endtask : run
  function automatic logic [15:0] add_ex(logic [7:0] x, y, logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic ov;
    s = {1'b0, x} + {1'b0, y} + {8'h00, c};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c};
    ov = (x[7] == y[7]) && (s[7] != x[7]);
    return {1'b0, ov ^ s[7], 2'b00, ov, s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction : add_ex
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      k = $random(seed);
      {a, m} = k[31:16];
      ad = k[13:3] | 11'h100;
      op = k[1] ? OP_AND : (k[0] ? OP_ADC : OP_ADD);
      e = add_ex(a, m, k[14] & (op == OP_ADC));
      if (op == OP_AND)
        e = {5'h00, (a & m) == 8'h00, 1'b0, k[14], a & m};
      bus(1'b1, REG_ACC, a);
      bus(1'b1, REG_STATUS, {7'h00, k[14]});
      mem_u.dm[ad] = m;
      instr_use_imm_i <= k[15] & ~k[2];
      instr_imm_i <= m;
      run(op, k[2], ad);
      chk(n, 2, "arith cycles");
      chk(pc_o, p + 14'h0001, "arith pc");
      chk(mem_u.dm[ad], k[2] ? e[7:0] : m, "mem");
      bus(1'b0, REG_ACC, 8'h00);
      chk(v, k[2] ? a : e[7:0], "acc");
      bus(1'b0, REG_STATUS, 8'h00);
      chk(v, e[15:8], "flags");
    end
    $display("arith test end");
    instr_use_imm_i <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      mem_u.dm[11'h7F0] = i ? 8'h05 : 8'h00;
      run(OP_SZ, 1'b1, 11'h7F0);
      chk(n, i ? 2 : 3, "skip cycles");
      chk(pc_o - p, i ? 14'h0001 : 14'h0002, "skip pc");
      chk(skip_o, i == 0, "skip flag");
    end
    $display("skip test end");
    foreach (dt[j])
    begin
      bus(1'b1, REG_ACC, dt[j][31:24]);
      bus(1'b1, REG_STATUS, dt[j][23:16]);
      run(OP_DAA, 1'b1, 11'h555);
      chk(mem_u.dm[11'h555], dt[j][15:8], "adjust");
      bus(1'b0, REG_STATUS, 8'h00);
      chk(v, dt[j][7:0], "adjust carry");
    end
    $display("adjust test end");
    bus(1'b1, REG_TABLE_POINTER, 8'h10);
    bus(1'b1, REG_TBHP, 8'h05);
    instr_incr_i <= 1'b1;
    run(OP_TABRD, 1'b1, 11'h321);
    chk(n, 3, "table cycles");
    chk(mem_u.dm[11'h321], 8'h11, "table low");
    bus(1'b0, REG_TABLE_HIGH_BYTE_REG, 8'h00);
    chk(v, 8'h85, "table high");
    {instr_incr_i, instr_last_i} <= 2'b01;
    run(OP_TABRD, 1'b1, 11'h322);
    bus(1'b1, REG_TABLE_HIGH_BYTE_REG, 8'h00);
    bus(1'b0, REG_TABLE_HIGH_BYTE_REG, 8'h00);
    chk(v, 8'hBF, "last page");
    $display("table test end");
    instr_target_i <= k[13:0];
    run(OP_CALL, 1'b0, 11'h000);
    chk(n, 2, "call cycles");
    chk(pc_o, k[13:0], "call target");
    for (int i = 0; i < 3; i++)
    begin
      mem_u.dm[11'h2C5] = 8'h96;
      bus(1'b1, REG_STATUS, 8'h01);
      run(i > 1 ? OP_CLR : i ? OP_RRC : OP_CPL, 1'b1, 11'h2C5);
      chk(mem_u.dm[11'h2C5], i > 1 ? 8'h00 : i ? 8'hCB : 8'h69,
        "unary");
    end
    for (int i = 0; i < 2; i++)
    begin
      mem_u.dm[11'h4A0] = i ? 8'h00 : 8'hFF;
      instr_bit_i <= 3'(3 + i * 3);
      run(i ? OP_SETB : OP_CLRB, 1'b1, 11'h4A0);
      chk(mem_u.dm[11'h4A0], i ? 8'h40 : 8'hF7, "bit op");
      chk(n, 2, "bit cycles");
    end
    bus(1'b1, REG_STATUS, 8'hFF);
    run(OP_CLRWDT, 1'b0, 11'h000);
    bus(1'b0, REG_STATUS, 8'h00);
    chk(v, 8'hCF, "watchdog clear");
    bus(1'b1, REG_ACC, 8'h40);
    run(OP_MOV, 1'b1, PCL_DM_ADDR);
    chk(n, 3, "pc low cycles");
    $display("misc test end");
    give_verdict;
  end
endmodule : ext_exec_core_tb
